// file: rtl/dtc_timer_unit.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
// How it works
// - Timer mode counts once per twelve clocks.
// - Counter mode counts falling edges on pin.
// - Count pins sampled each clock, edges compared.
// - Mode 0: 13-bit, divide-by-32 prescaler low bits.
// - Mode 0: low byte top bits indeterminate.
// - Mode 1: both bytes cascaded sixteen bits.
// - Mode 2: low byte reloads from high.
// - Rollover to zero sets overflow flag.
// - Mode 3: timer 0 low uses own controls.
// - Mode 3: timer 0 high uses timer 1 run/flag.
// - Timer 1 keeps counting, no interrupt flag.
// - Timer 1 mode 3 freezes its count.
// - Gate bit requires gate pin high too.
// - Counter-select picks pin or divided clock.
// - Mode register layout, resets zero.
// - Control register flags and run bits.
// - Flag clears on branch to its routine.
// - Software flag writes act like hardware.
// - Interrupt enable register: global and timer bits.
// - Priority register bits; top two undefined.
module dtc_timer_unit
  import dtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic timer0_gate_pin,
  input wire logic timer1_gate_pin,
  input wire logic timer0_isr_ack,
  input wire logic timer1_isr_ack,
  output logic timer0_irq_req,
  output logic timer1_irq_req,
  output logic timer0_irq_high_prio,
  output logic timer1_irq_high_prio,
  output logic timer1_overflow_pulse
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] cnt0_sync;
    logic [1:0] cnt1_sync;
    logic cnt0_prev;
    logic cnt1_prev;
    logic [1:0] timer0_gate_pin_sync;
    logic [1:0] timer1_gate_pin_sync;
    logic [3:0] tick_cnt;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [7:0] ie;
    logic [7:0] ip;
    logic [7:0] rdata;
    logic t1_ovf_pulse;
  } dtc_state_t;

  dtc_state_t state_q;
  dtc_state_t state_d;

  logic tick;
  logic edge0;
  logic edge1;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic [3:0] fld0;
  logic [3:0] fld1;
  dtc_mode_t mode0;
  dtc_mode_t mode1;
  logic ovf0;
  logic ovf1;
  logic ovf0_high;
  logic [8:0] sum;
  logic [5:0] pre;

  // ****************************************
  // Count sources and enables
  // ****************************************
  always_comb begin
    tick = (state_q.tick_cnt == DTC_TICK_LAST);
    // Edges are taken from the second and third stages only, never the first.
    edge0 = state_q.cnt0_prev & ~state_q.cnt0_sync[1];
    edge1 = state_q.cnt1_prev & ~state_q.cnt1_sync[1];
    fld0 = state_q.mode[DTC_MODE_T0_LSB +: 4];
    fld1 = state_q.mode[DTC_MODE_T1_LSB +: 4];
    mode0 = dtc_mode_t'(fld0[DTC_FLD_MHI:DTC_FLD_MLO]);
    mode1 = dtc_mode_t'(fld1[DTC_FLD_MHI:DTC_FLD_MLO]);
    en0 = state_q.ctrl[DTC_CTRL_T0_RUN] & (~fld0[DTC_FLD_GATE] | state_q.timer0_gate_pin_sync[1]);
    en1 = state_q.ctrl[DTC_CTRL_T1_RUN] & (~fld1[DTC_FLD_GATE] | state_q.timer1_gate_pin_sync[1]);
    inc0 = en0 & (fld0[DTC_FLD_CSEL] ? edge0 : tick);
    inc1 = en1 & (fld1[DTC_FLD_CSEL] ? edge1 : tick) & (mode1 != DTC_MODE_SPLIT);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf0_high = 1'b0;
    sum = '0;
    pre = '0;
    state_d.cnt0_sync = {state_q.cnt0_sync[0], timer0_count_pin};
    state_d.cnt1_sync = {state_q.cnt1_sync[0], timer1_count_pin};
    state_d.cnt0_prev = state_q.cnt0_sync[1];
    state_d.cnt1_prev = state_q.cnt1_sync[1];
    state_d.timer0_gate_pin_sync = {state_q.timer0_gate_pin_sync[0], timer0_gate_pin};
    state_d.timer1_gate_pin_sync = {state_q.timer1_gate_pin_sync[0], timer1_gate_pin};
    state_d.tick_cnt = tick ? '0 : state_q.tick_cnt + 4'h1;
    state_d.t1_ovf_pulse = 1'b0;
    state_d.rdata = DTC_RST_BYTE;

    // Software writes land first; counting below then overrides a write to any register it updates in the same cycle.
    if (reg_wr) begin
      if (reg_addr == DTC_ADDR_CTRL) begin
        state_d.ctrl = reg_wdata;
      end else if (reg_addr == DTC_ADDR_MODE) begin
        state_d.mode = reg_wdata;
      end else if (reg_addr == DTC_ADDR_T0_LOW) begin
        state_d.t0_low = reg_wdata;
      end else if (reg_addr == DTC_ADDR_T1_LOW) begin
        state_d.t1_low = reg_wdata;
      end else if (reg_addr == DTC_ADDR_T0_HIGH) begin
        state_d.t0_high = reg_wdata;
      end else if (reg_addr == DTC_ADDR_T1_HIGH) begin
        state_d.t1_high = reg_wdata;
      end else if (reg_addr == DTC_ADDR_IE) begin
        state_d.ie = reg_wdata;
      end else if (reg_addr == DTC_ADDR_IP) begin
        state_d.ip = reg_wdata & DTC_IP_IMPL_MASK;
      end
    end

    // Timer 0.
    if (inc0) begin
      case (mode0)
        DTC_MODE_13BIT: begin
          // The top three low bits are left as they are and carry no meaning.
          pre = {1'b0, state_q.t0_low[4:0]} + 6'h01;
          state_d.t0_low = (state_q.t0_low & ~DTC_PRESC_MASK) | {3'b000, pre[4:0]};
          if (pre[5]) begin
            sum = {1'b0, state_q.t0_high} + 9'h001;
            state_d.t0_high = sum[7:0];
            ovf0 = sum[8];
          end
        end
        DTC_MODE_16BIT: begin
          sum = {1'b0, state_q.t0_low} + 9'h001;
          state_d.t0_low = sum[7:0];
          if (sum[8]) begin
            state_d.t0_high = state_q.t0_high + DTC_BYTE_ONE;
            ovf0 = (state_q.t0_high == DTC_BYTE_ONES);
          end
        end
        DTC_MODE_RELOAD: begin
          sum = {1'b0, state_q.t0_low} + 9'h001;
          state_d.t0_low = sum[8] ? state_q.t0_high : sum[7:0];
          ovf0 = sum[8];
        end
        default: begin
          sum = {1'b0, state_q.t0_low} + 9'h001;
          state_d.t0_low = sum[7:0];
          ovf0 = sum[8];
        end
      endcase
    end
    // Split mode: the high byte is a plain timer gated by timer 1's run bit only.
    if (mode0 == DTC_MODE_SPLIT && state_q.ctrl[DTC_CTRL_T1_RUN] && tick) begin
      state_d.t0_high = state_q.t0_high + DTC_BYTE_ONE;
      ovf0_high = (state_q.t0_high == DTC_BYTE_ONES);
    end

    // Timer 1.
    if (inc1) begin
      case (mode1)
        DTC_MODE_13BIT: begin
          pre = {1'b0, state_q.t1_low[4:0]} + 6'h01;
          state_d.t1_low = (state_q.t1_low & ~DTC_PRESC_MASK) | {3'b000, pre[4:0]};
          if (pre[5]) begin
            sum = {1'b0, state_q.t1_high} + 9'h001;
            state_d.t1_high = sum[7:0];
            ovf1 = sum[8];
          end
        end
        DTC_MODE_16BIT: begin
          sum = {1'b0, state_q.t1_low} + 9'h001;
          state_d.t1_low = sum[7:0];
          if (sum[8]) begin
            state_d.t1_high = state_q.t1_high + DTC_BYTE_ONE;
            ovf1 = (state_q.t1_high == DTC_BYTE_ONES);
          end
        end
        default: begin
          sum = {1'b0, state_q.t1_low} + 9'h001;
          state_d.t1_low = sum[8] ? state_q.t1_high : sum[7:0];
          ovf1 = sum[8];
        end
      endcase
    end
    // Timer 1 still paces the serial channel while timer 0 owns its flag.
    state_d.t1_ovf_pulse = ovf1;

    // Flags: ISR acknowledge clears, but a hardware set in the same cycle wins.
    if (timer0_isr_ack) begin
      state_d.ctrl[DTC_CTRL_T0_OVF] = 1'b0;
    end
    if (timer1_isr_ack) begin
      state_d.ctrl[DTC_CTRL_T1_OVF] = 1'b0;
    end
    if (ovf0) begin
      state_d.ctrl[DTC_CTRL_T0_OVF] = 1'b1;
    end
    if (mode0 == DTC_MODE_SPLIT) begin
      if (ovf0_high) begin
        state_d.ctrl[DTC_CTRL_T1_OVF] = 1'b1;
      end
    end else if (ovf1) begin
      state_d.ctrl[DTC_CTRL_T1_OVF] = 1'b1;
    end

    // Read data stands only in the cycle after the strobe.
    if (reg_rd) begin
      if (reg_addr == DTC_ADDR_CTRL) begin
        state_d.rdata = state_q.ctrl;
      end else if (reg_addr == DTC_ADDR_MODE) begin
        state_d.rdata = state_q.mode;
      end else if (reg_addr == DTC_ADDR_T0_LOW) begin
        state_d.rdata = state_q.t0_low;
      end else if (reg_addr == DTC_ADDR_T1_LOW) begin
        state_d.rdata = state_q.t1_low;
      end else if (reg_addr == DTC_ADDR_T0_HIGH) begin
        state_d.rdata = state_q.t0_high;
      end else if (reg_addr == DTC_ADDR_T1_HIGH) begin
        state_d.rdata = state_q.t1_high;
      end else if (reg_addr == DTC_ADDR_IE) begin
        state_d.rdata = state_q.ie;
      end else if (reg_addr == DTC_ADDR_IP) begin
        state_d.rdata = state_q.ip;
      end else begin
        state_d.rdata = DTC_RST_BYTE;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = state_q.rdata;
  assign timer0_irq_req = state_q.ie[DTC_IE_GLOBAL] & state_q.ie[DTC_IE_T0] & state_q.ctrl[DTC_CTRL_T0_OVF];
  assign timer1_irq_req = state_q.ie[DTC_IE_GLOBAL] & state_q.ie[DTC_IE_T1] & state_q.ctrl[DTC_CTRL_T1_OVF];
  assign timer0_irq_high_prio = state_q.ip[DTC_IP_T0];
  assign timer1_irq_high_prio = state_q.ip[DTC_IP_T1];
  assign timer1_overflow_pulse = state_q.t1_ovf_pulse;

endmodule // dtc_timer_unit

// file: pkg/dtc_pkg.sv
package dtc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_T0_LOW = 8'h8a;
  localparam logic [7:0] DTC_ADDR_T1_LOW = 8'h8b;
  localparam logic [7:0] DTC_ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] DTC_ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] DTC_ADDR_IE = 8'ha8;
  localparam logic [7:0] DTC_ADDR_IP = 8'hb8;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] DTC_RST_BYTE = 8'h00;
  localparam int DTC_CTRL_T1_OVF = 7;
  localparam int DTC_CTRL_T1_RUN = 6;
  localparam int DTC_CTRL_T0_OVF = 5;
  localparam int DTC_CTRL_T0_RUN = 4;
  localparam int DTC_MODE_T1_LSB = 4;
  localparam int DTC_MODE_T0_LSB = 0;
  localparam int DTC_FLD_GATE = 3;
  localparam int DTC_FLD_CSEL = 2;
  localparam int DTC_FLD_MHI = 1;
  localparam int DTC_FLD_MLO = 0;
  localparam int DTC_IE_GLOBAL = 7;
  localparam int DTC_IE_T1 = 3;
  localparam int DTC_IE_T0 = 1;
  localparam int DTC_IP_T1 = 3;
  localparam int DTC_IP_T0 = 1;
  localparam logic [7:0] DTC_IP_IMPL_MASK = 8'h3f;
  localparam logic [7:0] DTC_PRESC_MASK = 8'h1f;
  localparam logic [7:0] DTC_BYTE_ONES = 8'hff;
  localparam logic [7:0] DTC_BYTE_ONE = 8'h01;

  // ****************************************
  // Timing
  // ****************************************
  localparam int DTC_TICK_DIV = 12;
  localparam logic [3:0] DTC_TICK_LAST = 4'(DTC_TICK_DIV - 1);

  typedef enum logic [1:0] {
    DTC_MODE_13BIT = 2'b00,
    DTC_MODE_16BIT = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_t;

endpackage

// file: sim/dtc_pins.sv
`timescale 1ns/1ns
// ****************************************
// Count and gate pin driver
// ****************************************
// Each request holds a count pin low for four clocks, so the per-clock sampling always sees the edge.
module dtc_pins (
  input wire logic ref_clk,
  input wire logic [1:0] fall_req,
  input wire logic [1:0] gate_lvl,
  output logic timer0_count_pin,
  output logic timer1_count_pin,
  output logic timer0_gate_pin,
  output logic timer1_gate_pin
);
  logic [2:0] low0_q = 3'h0;
  logic [2:0] low1_q = 3'h0;
  always_ff @(posedge ref_clk) begin
    low0_q <= fall_req[0] ? 3'h4 : low0_q - 3'(low0_q != 3'h0);
    low1_q <= fall_req[1] ? 3'h4 : low1_q - 3'(low1_q != 3'h0);
  end
  assign timer0_count_pin = (low0_q == 3'h0);
  assign timer1_count_pin = (low1_q == 3'h0);
  assign timer0_gate_pin = gate_lvl[0];
  assign timer1_gate_pin = gate_lvl[1];
endmodule // dtc_pins

// file: sim/dtc_chk.sv
`timescale 1ns/1ns
// ****************************************
// Port checker
// ****************************************
module dtc_chk
  import dtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic timer0_irq_req,
  input wire logic timer1_irq_req,
  input wire logic timer0_irq_high_prio,
  input wire logic timer1_irq_high_prio,
  input wire logic timer1_overflow_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; clk_en && !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped; clk_en && reg_rd && reg_addr[7:4] == 4'h9 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ip_rd; clk_en && reg_rd && reg_addr == DTC_ADDR_IP |=> reg_rdata[7:6] == 2'b00 &&
    reg_rdata[3] == timer1_irq_high_prio && reg_rdata[1] == timer0_irq_high_prio; endproperty
  a_ip_rd: assert property (p_ip_rd) else $error("priority read mismatch");
  property p_ip_wr; clk_en && reg_wr && reg_addr == DTC_ADDR_IP |=>
    {timer1_irq_high_prio, timer0_irq_high_prio} == {$past(reg_wdata[3]), $past(reg_wdata[1])}; endproperty
  a_ip_wr: assert property (p_ip_wr) else $error("priority outputs not updated");
  property p_ie_rd; clk_en && reg_rd && reg_addr == DTC_ADDR_IE ##1 !reg_rdata[7] |->
    !timer0_irq_req && !timer1_irq_req; endproperty
  a_ie_rd: assert property (p_ie_rd) else $error("request without global enable");
  property p_ie_wr; clk_en && reg_wr && reg_addr == DTC_ADDR_IE && !reg_wdata[7] |=>
    !timer0_irq_req && !timer1_irq_req; endproperty
  a_ie_wr: assert property (p_ie_wr) else $error("request after global mask");
  property p_pulse; clk_en && timer1_overflow_pulse |=> !timer1_overflow_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("overflow pulse too long");
  property p_reset; $rose(rst_n) |-> reg_rdata == 8'h00 && !timer0_irq_req && !timer1_irq_req; endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
  c_pulse: cover property (timer1_overflow_pulse);
  c_irq0: cover property (timer0_irq_req);
  c_irq1: cover property (timer1_irq_req);
endmodule // dtc_chk
bind dtc_timer_unit dtc_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .timer0_irq_req(timer0_irq_req), .timer1_irq_req(timer1_irq_req), .timer0_irq_high_prio(timer0_irq_high_prio),
  .timer1_irq_high_prio(timer1_irq_high_prio), .timer1_overflow_pulse(timer1_overflow_pulse));

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench
  import dtc_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer0_isr_ack = 1'b0;
  logic timer1_isr_ack = 1'b0;
  logic [1:0] fall_req = 2'b00;
  logic [1:0] gate_lvl = 2'b00;
  logic [7:0] reg_rdata;
  logic c0, c1, g0, g1, irq0, irq1, hp0, hp1, t1_pulse;
  int err_total = 0;
  int comparisons = 0;
  int pulse_cnt = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (t1_pulse) pulse_cnt <= pulse_cnt + 1;
  dtc_pins u_pins (.ref_clk(ref_clk), .fall_req(fall_req), .gate_lvl(gate_lvl), .timer0_count_pin(c0),
    .timer1_count_pin(c1), .timer0_gate_pin(g0), .timer1_gate_pin(g1));
  dtc_timer_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_count_pin(c0),
    .timer1_count_pin(c1), .timer0_gate_pin(g0), .timer1_gate_pin(g1), .timer0_isr_ack(timer0_isr_ack),
    .timer1_isr_ack(timer1_isr_ack), .timer0_irq_req(irq0), .timer1_irq_req(irq1),
    .timer0_irq_high_prio(hp0), .timer1_irq_high_prio(hp1), .timer1_overflow_pulse(t1_pulse));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // A following write raises the strobe again one step later, never in this time step.
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, reg_rdata & m);
  endtask
  task automatic chk_irq(input logic [1:0] e);
    #1 chk("irq", {6'h00, e}, {6'h00, irq1, irq0});
  endtask
  // One run window covers exactly 120 enabled clocks, hence ten divided ticks.
  task automatic run_case(input logic [7:0] md, input logic [31:0] pre, input logic [31:0] exp,
                          input logic [1:0] irq, input int pulses);
    int p0;
    wr(DTC_ADDR_MODE, md);
    wr(DTC_ADDR_T0_LOW, pre[7:0]);
    wr(DTC_ADDR_T0_HIGH, pre[15:8]);
    wr(DTC_ADDR_T1_LOW, pre[23:16]);
    wr(DTC_ADDR_T1_HIGH, pre[31:24]);
    p0 = pulse_cnt;
    wr(DTC_ADDR_CTRL, 8'h50);
    repeat (119) @(posedge ref_clk);
    chk_irq(irq);
    wr(DTC_ADDR_CTRL, 8'h00);
    chk_irq(2'b00);
    chk("pulses", 8'(pulses), 8'(pulse_cnt - p0));
    rd(DTC_ADDR_T0_LOW, md[1:0] == 2'b00 ? DTC_PRESC_MASK : 8'hff, exp[7:0]);
    rd(DTC_ADDR_T0_HIGH, 8'hff, exp[15:8]);
    rd(DTC_ADDR_T1_LOW, md[5:4] == 2'b00 ? DTC_PRESC_MASK : 8'hff, exp[23:16]);
    rd(DTC_ADDR_T1_HIGH, 8'hff, exp[31:24]);
  endtask
  task automatic t_count();
    wr(DTC_ADDR_MODE, 8'h55);
    wr(DTC_ADDR_T0_LOW, 8'h00);
    wr(DTC_ADDR_T1_LOW, 8'h00);
    wr(DTC_ADDR_CTRL, 8'h50);
    repeat (5) begin
      fall_req <= 2'b11;
      @(posedge ref_clk);
      fall_req <= 2'b00;
      repeat (9) @(posedge ref_clk);
    end
    wr(DTC_ADDR_CTRL, 8'h00);
    rd(DTC_ADDR_T0_LOW, 8'hff, 8'h05);
    rd(DTC_ADDR_T1_LOW, 8'hff, 8'h05);
  endtask
  task automatic t_flags();
    wr(DTC_ADDR_CTRL, 8'ha0);
    chk_irq(2'b11);
    timer0_isr_ack <= 1'b1;
    @(posedge ref_clk);
    timer0_isr_ack <= 1'b0;
    chk_irq(2'b10);
    timer1_isr_ack <= 1'b1;
    @(posedge ref_clk);
    timer1_isr_ack <= 1'b0;
    chk_irq(2'b00);
    wr(DTC_ADDR_CTRL, 8'ha0);
    wr(DTC_ADDR_IE, 8'h00);
    chk_irq(2'b00);
  endtask
  // A write made while the clock enable is low must leave the register untouched.
  task automatic t_freeze();
    wr(DTC_ADDR_T0_LOW, 8'h11);
    clk_en <= 1'b0;
    wr(DTC_ADDR_T0_LOW, 8'h55);
    clk_en <= 1'b1;
    rd(DTC_ADDR_T0_LOW, 8'hff, 8'h11);
  endtask
  task automatic conclude();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (DTC_RST_BYTE[i]) rd(8'h88 + 8'(i), 8'hff, 8'h00);
    rd(DTC_ADDR_IE, 8'hff, 8'h00);
    rd(DTC_ADDR_IP, 8'hff, 8'h00);
    wr(DTC_ADDR_IP, 8'hff);
    rd(DTC_ADDR_IP, 8'hff, 8'h3f);
    chk("prio", 8'h03, {6'h00, hp1, hp0});
    rd(8'h90, 8'hff, 8'h00);
    wr(DTC_ADDR_IE, 8'h8a);
    run_case(8'h00, 32'hff1c_ff1c, 32'h0006_0006, 2'b11, 1);
    run_case(8'h11, 32'hfff8_fff8, 32'h0002_0002, 2'b11, 1);
    run_case(8'h22, 32'hf0fb_f0fb, 32'hf0f5_f0f5, 2'b11, 1);
    run_case(8'h13, 32'hfff8_00f8, 32'h0002_0a02, 2'b01, 1);
    run_case(8'h33, 32'h5555_fa00, 32'h5555_040a, 2'b10, 0);
    run_case(8'h09, 32'h0000_0000, 32'h000a_0000, 2'b00, 0);
    gate_lvl <= 2'b01;
    run_case(8'h09, 32'h0000_0000, 32'h000a_000a, 2'b00, 0);
    t_count();
    t_flags();
    t_freeze();
    conclude();
  end
endmodule // testbench
